// ==== verilog/pscr_defines.svh ====
`ifndef PSCR_DEFINES_SVH
`define PSCR_DEFINES_SVH
// ==========================================================
// Register offsets
`define PSCR_ADDR_PLL_CTL 8'h0a
`define PSCR_ADDR_LOOP 8'h0c
`define PSCR_ADDR_DIV 8'h0d
`define PSCR_ADDR_LOCK 8'h0e
`define PSCR_ADDR_BAND 8'h0f
`define PSCR_ADDR_SYNC 8'h10
// ==========================================================
// Field positions
`define PSCR_PLL_EN_BIT 7
`define PSCR_MANUAL_BIT 6
`define PSCR_BAND_MSB 5
`define PSCR_BW_MSB 7
`define PSCR_BW_LSB 5
`define PSCR_CP_MSB 4
`define PSCR_CTLDIV_MSB 7
`define PSCR_CTLDIV_LSB 6
`define PSCR_XPT_BIT 4
`define PSCR_VCODIV_MSB 3
`define PSCR_VCODIV_LSB 2
`define PSCR_FBDIV_MSB 1
`define PSCR_LOCK_BIT 7
`define PSCR_VOLT_MSB 3
`define PSCR_SYNC_EN_BIT 7
`define PSCR_RATE_BIT 6
`define PSCR_EDGE_BIT 3
`define PSCR_AVG_MSB 2
// ==========================================================
// Reset values
`define PSCR_RST_PLL_EN 1'b0
`define PSCR_RST_MANUAL 1'b1
`define PSCR_RST_BAND 6'h00
`define PSCR_RST_BW 3'h6
`define PSCR_RST_CP 5'h11
`define PSCR_RST_CTLDIV 2'h3
`define PSCR_RST_XPT 1'b1
`define PSCR_RST_VCODIV 2'h2
`define PSCR_RST_FBDIV 2'h1
`define PSCR_RST_SYNC_EN 1'b0
`define PSCR_RST_RATE 1'b1
`define PSCR_RST_EDGE 1'b1
`define PSCR_RST_AVG 3'h0
`endif

// ==== verilog/pscr_pkg.sv ====
`default_nettype none
package pscr_pkg;
  // ==========================================================
  // PLL settings as driven to the analog loop
  typedef struct packed {
    logic enable;          // Multiplier on
    logic manual;          // Manual band select
    logic [5:0] band;      // Band in use
    logic [2:0] loop_bw;   // Loop filter bandwidth code
    logic [4:0] cp_cur;    // Charge-pump current code
    logic [4:0] controller_clock_divider; // Ratio 2..16
    logic xpt_en;          // Cross-point controller on
    logic [2:0] vco_output_divider;       // Ratio 1, 2 or 4
    logic [4:0] loop_feedback_divider;    // Ratio 2..16
  } pscr_pll_cfg_t;
  // ==========================================================
  // Sync settings as driven to the sync logic
  typedef struct packed {
    logic enable;          // Sync logic on
    logic data_rate;       // 1 = data rate, 0 = FIFO reset rate
    logic rising;          // Start edge select
    logic [7:0] avg_count; // Samples averaged
  } pscr_sync_cfg_t;
  // ==========================================================
  // Status from the analog loop
  typedef struct packed {
    logic locked;          // Tracking the reference
    logic [3:0] volt;      // Control voltage code
    logic [5:0] auto_band; // Band chosen by calibration
  } pscr_pll_stat_t;
endpackage : pscr_pkg
`default_nettype wire

// ==== verilog/pscr_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pscr_defines.svh"
// Overview of operation
// - Enable bit turns PLL on
// - Manual band mode, resets to one
// - Manual band field picks VCO band
// - Loop bandwidth code, reset 110
// - Charge-pump current code, reset 10001
// - Controller clock divider 2 to 16
// - Cross-point controller enable, set at reset
// - VCO divider 1, 2, 4, 4
// - Feedback divider 2 to 16, reset 01
// - Lock bit shows PLL tracking
// - Four-bit control voltage readback
// - Band readback shows band in use
// - Sync enable bit, reset off
// - Sync rate select, reset data rate
// - Sync start edge select, reset rising
// - Averaging codes give 1 to 128
module pscr_top
  import pscr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire pscr_pll_stat_t pll_stat_i,
  input wire logic sync_pin_i,
  output pscr_pll_cfg_t pll_cfg_o,
  output pscr_sync_cfg_t sync_cfg_o,
  output logic sync_start_o
);

  // ==========================================================
  // Helpers

  // Power-of-two ratio from a code, shared by all dividers.
  // Code is at most 7, so the result always fits in 8 bits.
  function automatic logic [7:0] pow2(input logic [2:0] code);
    pow2 = 8'h01 << code;
  endfunction : pow2

  // Address match for a write strobe
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    hit = (a == ref_a);
  endfunction : hit

  // ==========================================================
  // Configuration registers

  // Stored fields, only functional bits are kept
  logic pll_en_ff, nxt_pll_en;
  logic manual_ff, nxt_manual;
  logic [5:0] band_ff, nxt_band;
  logic [2:0] bw_ff, nxt_bw;
  logic [4:0] cp_ff, nxt_cp;
  logic [1:0] ctldiv_ff, nxt_ctldiv;
  logic xpt_ff, nxt_xpt;
  logic [1:0] vcodiv_ff, nxt_vcodiv;
  logic [1:0] fbdiv_ff, nxt_fbdiv;
  logic sync_en_ff, nxt_sync_en;
  logic rate_ff, nxt_rate;
  logic edge_ff, nxt_edge;
  logic [2:0] avg_ff, nxt_avg;

  // Write decode; bits with no field are simply dropped
  always_comb begin
    nxt_pll_en = pll_en_ff;
    nxt_manual = manual_ff;
    nxt_band = band_ff;
    nxt_bw = bw_ff;
    nxt_cp = cp_ff;
    nxt_ctldiv = ctldiv_ff;
    nxt_xpt = xpt_ff;
    nxt_vcodiv = vcodiv_ff;
    nxt_fbdiv = fbdiv_ff;
    nxt_sync_en = sync_en_ff;
    nxt_rate = rate_ff;
    nxt_edge = edge_ff;
    nxt_avg = avg_ff;
    // Only a write strobe moves a field; otherwise every field holds
    if (reg_wr_i) begin
      // Enable, band mode and manual band
      if (hit(reg_addr_i, `PSCR_ADDR_PLL_CTL)) begin
        nxt_pll_en = reg_wdata_i[`PSCR_PLL_EN_BIT];
        nxt_manual = reg_wdata_i[`PSCR_MANUAL_BIT];
        nxt_band = reg_wdata_i[`PSCR_BAND_MSB:0];
      end
      // Loop bandwidth and charge-pump current
      if (hit(reg_addr_i, `PSCR_ADDR_LOOP)) begin
        nxt_bw = reg_wdata_i[`PSCR_BW_MSB:`PSCR_BW_LSB];
        nxt_cp = reg_wdata_i[`PSCR_CP_MSB:0];
      end
      // Divider ratios and cross-point control
      if (hit(reg_addr_i, `PSCR_ADDR_DIV)) begin
        nxt_ctldiv = reg_wdata_i[`PSCR_CTLDIV_MSB:`PSCR_CTLDIV_LSB];
        nxt_xpt = reg_wdata_i[`PSCR_XPT_BIT];
        nxt_vcodiv = reg_wdata_i[`PSCR_VCODIV_MSB:`PSCR_VCODIV_LSB];
        nxt_fbdiv = reg_wdata_i[`PSCR_FBDIV_MSB:0];
      end
      // Sync enable, rate, edge and averaging
      if (hit(reg_addr_i, `PSCR_ADDR_SYNC)) begin
        nxt_sync_en = reg_wdata_i[`PSCR_SYNC_EN_BIT];
        nxt_rate = reg_wdata_i[`PSCR_RATE_BIT];
        nxt_edge = reg_wdata_i[`PSCR_EDGE_BIT];
        nxt_avg = reg_wdata_i[`PSCR_AVG_MSB:0];
      end
      // Status offsets are read-only, writes there are ignored
    end
  end

  // Register the fields; reset values set the power-up mode
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      // Power-up values of every stored field
      pll_en_ff <= `PSCR_RST_PLL_EN;
      manual_ff <= `PSCR_RST_MANUAL;
      band_ff <= `PSCR_RST_BAND;
      bw_ff <= `PSCR_RST_BW;
      cp_ff <= `PSCR_RST_CP;
      ctldiv_ff <= `PSCR_RST_CTLDIV;
      xpt_ff <= `PSCR_RST_XPT;
      vcodiv_ff <= `PSCR_RST_VCODIV;
      fbdiv_ff <= `PSCR_RST_FBDIV;
      sync_en_ff <= `PSCR_RST_SYNC_EN;
      rate_ff <= `PSCR_RST_RATE;
      edge_ff <= `PSCR_RST_EDGE;
      avg_ff <= `PSCR_RST_AVG;
    end else begin
      // Normal operation: take the decoded next values
      pll_en_ff <= nxt_pll_en;
      manual_ff <= nxt_manual;
      band_ff <= nxt_band;
      bw_ff <= nxt_bw;
      cp_ff <= nxt_cp;
      ctldiv_ff <= nxt_ctldiv;
      xpt_ff <= nxt_xpt;
      vcodiv_ff <= nxt_vcodiv;
      fbdiv_ff <= nxt_fbdiv;
      sync_en_ff <= nxt_sync_en;
      rate_ff <= nxt_rate;
      edge_ff <= nxt_edge;
      avg_ff <= nxt_avg;
    end
  end

  // ==========================================================
  // Synchronisers for the analog status and the sync pin

  // Status comes from the loop's own clocks, so two stages each.
  // Multi-bit codes may tear for one sample while changing; the
  // codes move slowly, so software simply rereads if in doubt.
  pscr_pll_stat_t stat_meta_ff, stat_sync_ff;
  logic pin_meta_ff, pin_sync_ff, pin_prev_ff;
  logic nxt_start;

  // Chosen edge of the synced pin, only while sync is enabled
  always_comb begin
    nxt_start = 1'b0;
    if (sync_en_ff) begin
      if (edge_ff) begin
        // Rising: high now, low one sample before
        nxt_start = pin_sync_ff & ~pin_prev_ff;
      end else begin
        // Falling: low now, high one sample before
        nxt_start = ~pin_sync_ff & pin_prev_ff;
      end
    end
  end

  // Synchroniser chains and edge history.
  // History resets low; a pin that idles high would look like a
  // rising edge just after reset, but sync enable is off then too.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      // Both stages clear so no stale status shows after reset
      stat_meta_ff <= '0;
      stat_sync_ff <= '0;
      pin_meta_ff <= 1'b0;
      pin_sync_ff <= 1'b0;
      pin_prev_ff <= 1'b0;
    end else begin
      stat_meta_ff <= pll_stat_i;
      stat_sync_ff <= stat_meta_ff;
      pin_meta_ff <= sync_pin_i;
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
    end
  end

  // ==========================================================
  // Decoded outputs

  pscr_pll_cfg_t nxt_pll_cfg;
  pscr_sync_cfg_t nxt_sync_cfg;
  logic [5:0] band_used; // Band actually steering the VCO

  // Manual mode uses the field, otherwise the calibrated band
  assign band_used = manual_ff ? band_ff : stat_sync_ff.auto_band;

  // Raw ratios; only the low bits reach the outputs, the rest stay
  // zero because no code asks for a ratio above sixteen
  logic [2:0] ctl_code; // Controller code plus one
  logic [2:0] fb_code; // Feedback code plus one
  logic [7:0] ctl_ratio; // Controller clock ratio, 2..16
  logic [7:0] vco_ratio; // VCO ratio for the two low codes
  logic [7:0] fb_ratio; // Feedback ratio, 2..16

  // Code 0 means divide by two, hence the offset of one
  assign ctl_code = {1'b0, ctldiv_ff} + 3'h1;
  assign fb_code = {1'b0, fbdiv_ff} + 3'h1;
  assign ctl_ratio = pow2(ctl_code);
  assign vco_ratio = pow2({1'b0, vcodiv_ff});
  assign fb_ratio = pow2(fb_code);

  // Ratios decoded once here so the analog side sees plain numbers
  always_comb begin
    nxt_pll_cfg.enable = pll_en_ff;
    nxt_pll_cfg.manual = manual_ff;
    nxt_pll_cfg.band = band_used;
    nxt_pll_cfg.loop_bw = bw_ff;
    nxt_pll_cfg.cp_cur = cp_ff;
    // Codes 0..3 give 2..16; controller clock limit is software's job
    nxt_pll_cfg.controller_clock_divider = ctl_ratio[4:0];
    nxt_pll_cfg.xpt_en = xpt_ff;
    // Top two codes both give divide by four
    nxt_pll_cfg.vco_output_divider = vcodiv_ff[1] ? 3'h4 : vco_ratio[2:0];
    nxt_pll_cfg.loop_feedback_divider = fb_ratio[4:0];
    nxt_sync_cfg.enable = sync_en_ff;
    nxt_sync_cfg.data_rate = rate_ff;
    nxt_sync_cfg.rising = edge_ff;
    // Full 3-bit range: 1..32, then 64 and 128
    nxt_sync_cfg.avg_count = pow2(avg_ff);
  end

  // ==========================================================
  // Read port

  logic [7:0] nxt_rdata;

  // Read mux; unused bits and unmapped offsets read as zero
  always_comb begin
    nxt_rdata = 8'h00;
    case (reg_addr_i)
      // Enable, mode and manual band
      `PSCR_ADDR_PLL_CTL: begin
        nxt_rdata = {pll_en_ff, manual_ff, band_ff};
      end
      // Loop bandwidth and charge-pump current
      `PSCR_ADDR_LOOP: begin
        nxt_rdata = {bw_ff, cp_ff};
      end
      // Dividers, bit 5 unused
      `PSCR_ADDR_DIV: begin
        nxt_rdata = {ctldiv_ff, 1'b0, xpt_ff, vcodiv_ff, fbdiv_ff};
      end
      // Synced lock level and control voltage
      `PSCR_ADDR_LOCK: begin
        nxt_rdata[`PSCR_LOCK_BIT] = stat_sync_ff.locked;
        nxt_rdata[`PSCR_VOLT_MSB:0] = stat_sync_ff.volt;
      end
      // Band actually in use
      `PSCR_ADDR_BAND: begin
        nxt_rdata = {2'h0, band_used};
      end
      // Sync settings, bits 5:4 unused
      `PSCR_ADDR_SYNC: begin
        nxt_rdata = {sync_en_ff, rate_ff, 2'h0, edge_ff, avg_ff};
      end
      // Gaps in the map and all other offsets
      default: begin
        nxt_rdata = 8'h00;
      end
    endcase
  end

  // Every output comes straight from a flop
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      // Outputs idle at zero while reset is held
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
      pll_cfg_o <= '0;
      sync_cfg_o <= '0;
      sync_start_o <= 1'b0;
    end else begin
      // Read data is captured only on a read and then holds, so
      // software may look at it any time before the next read
      if (reg_rd_i) begin
        reg_rdata_o <= nxt_rdata;
      end
      reg_rvalid_o <= reg_rd_i;
      pll_cfg_o <= nxt_pll_cfg;
      sync_cfg_o <= nxt_sync_cfg;
      sync_start_o <= nxt_start;
    end
  end

endmodule : pscr_top
`default_nettype wire

// ==== tb/pscr_top_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port checks of the PLL and sync register block
module pscr_top_asserts
  import pscr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire pscr_pll_stat_t pll_stat_i,
  input wire logic sync_pin_i,
  input wire pscr_pll_cfg_t pll_cfg_o,
  input wire pscr_sync_cfg_t sync_cfg_o,
  input wire logic sync_start_o
);
  // Write decodes per register
  wire logic w_pll = reg_wr_i && reg_addr_i == 8'h0a;
  wire logic w_loop = reg_wr_i && reg_addr_i == 8'h0c;
  wire logic w_div = reg_wr_i && reg_addr_i == 8'h0d;
  wire logic w_sync = reg_wr_i && reg_addr_i == 8'h10;
  wire logic lk = pll_stat_i.locked; // Lock level alone
  logic [7:0] wd1; // Write data one edge back
  logic [7:0] wd2; // Two edges back, lines up with the config output
  // Delay line only; no reset, read only after a write
  always_ff @(posedge clk_i) begin
    wd1 <= reg_wdata_i;
    wd2 <= wd1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  pll_enable_a: assert property (w_pll ##1 !w_pll |=> pll_cfg_o.enable == wd2[7])
    else $error("pll enable wrong");
  band_mode_a: assert property (w_pll ##1 !w_pll |=> pll_cfg_o.manual == wd2[6] && (!wd2[6] || pll_cfg_o.band == wd2[5:0]))
    else $error("band mode wrong");
  loop_tuning_a: assert property (w_loop ##1 !w_loop |=> {pll_cfg_o.loop_bw, pll_cfg_o.cp_cur} == wd2)
    else $error("loop tuning wrong");
  ctl_divider_a: assert property (w_div ##1 !w_div |=> pll_cfg_o.controller_clock_divider == 5'h2 << wd2[7:6])
    else $error("controller divider wrong");
  vco_divider_a: assert property (w_div ##1 !w_div |=> pll_cfg_o.vco_output_divider == (wd2[3] ? 3'h4 : 3'h1 << wd2[2]))
    else $error("vco divider wrong");
  fb_divider_a: assert property (w_div ##1 !w_div |=> pll_cfg_o.loop_feedback_divider == 5'h2 << wd2[1:0])
    else $error("feedback divider wrong");
  sync_config_a: assert property (w_sync ##1 !w_sync |=> sync_cfg_o == pscr_sync_cfg_t'({wd2[7], wd2[6], wd2[3], 8'h01 << wd2[2:0]}))
    else $error("sync config wrong");
  sync_gate_a: assert property (!sync_cfg_o.enable |-> !sync_start_o)
    else $error("sync start while disabled");
  sync_edge_a: assert property (sync_cfg_o.enable && (sync_cfg_o.rising ? $rose(sync_pin_i) : $fell(sync_pin_i)) |-> ##[2:4] sync_start_o)
    else $error("sync start missing");
  lock_read_a: assert property ($stable(pll_stat_i) [*3] ##0 (reg_rd_i && reg_addr_i == 8'h0e) |=> reg_rdata_o[7] == $past(lk))
    else $error("lock readback wrong");
  unused_zero_a: assert property (reg_rd_i && reg_addr_i == 8'h0d |=> reg_rvalid_o && !reg_rdata_o[5])
    else $error("unused bit not zero");
endmodule : pscr_top_asserts
bind pscr_top pscr_top_asserts i_pscr_top_asserts (.clk_i, .rst_i, .reg_wr_i, .reg_rd_i,
  .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .pll_stat_i, .sync_pin_i,
  .pll_cfg_o, .sync_cfg_o, .sync_start_o);
`default_nettype wire

// ==== tb/pscr_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench with a register image as reference model
module pscr_top_tb;
  import pscr_pkg::*;
  logic clk_i;
  logic rst_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic sync_pin_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic reg_rvalid_o;
  logic sync_start_o;
  pscr_pll_stat_t pll_stat_i = '0; // Analog loop status stand-in
  pscr_pll_cfg_t pll_cfg_o;
  pscr_sync_cfg_t sync_cfg_o;
  logic [7:0] mdl [0:255]; // Register image, unmapped stays zero
  logic [7:0] adr [0:7] = '{8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11};
  logic [31:0] r;
  int n_mismatch = 0;
  int checks_done = 0;
  int n_start = 0; // Sync start pulses seen
  int seed = 32'h0a61;
  pscr_top i_pscr_top (.clk_i, .rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
    .reg_rdata_o, .reg_rvalid_o, .pll_stat_i, .sync_pin_i, .pll_cfg_o, .sync_cfg_o,
    .sync_start_o);
  // ==========================================================
  // Clock and pulse counter
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (sync_start_o === 1'b1) n_start++;
  // ==========================================================
  // Model of the register contents
  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      8'h0a, 8'h0c: msk = 8'hff;
      8'h0d: msk = 8'hdf; // Bit 5 unused
      8'h10: msk = 8'hcf; // Bits 5:4 unused
      default: msk = 8'h00; // Status and unmapped ignore writes
    endcase
  endfunction : msk
  function automatic logic [7:0] erd(input logic [7:0] a);
    case (a)
      8'h0e: erd = {pll_stat_i.locked, 3'h0, pll_stat_i.volt};
      8'h0f: erd = {2'h0, mdl[8'h0a][6] ? mdl[8'h0a][5:0] : pll_stat_i.auto_band};
      default: erd = mdl[a];
    endcase
  endfunction : erd
  function automatic pscr_pll_cfg_t ecfg();
    logic [7:0] a = mdl[8'h0a];
    logic [7:0] c = mdl[8'h0c];
    logic [7:0] d = mdl[8'h0d];
    ecfg = pscr_pll_cfg_t'({a[7], a[6], a[6] ? a[5:0] : pll_stat_i.auto_band, c,
      5'h2 << d[7:6], d[4], d[3] ? 3'h4 : 3'h1 << d[2], 5'h2 << d[1:0]});
  endfunction : ecfg
  function automatic pscr_sync_cfg_t escfg();
    logic [7:0] s = mdl[8'h10];
    escfg = pscr_sync_cfg_t'({s[7], s[6], s[3], 8'h01 << s[2:0]});
  endfunction : escfg
  // ==========================================================
  // Compare, bus cycles and sync edges
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One idle edge after each strobe so no strobe is set twice in a step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    mdl[a] = (mdl[a] & ~msk(a)) | (d & msk(a));
    @(posedge clk_i);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rvalid_o, 32'h1);
    chk(reg_rdata_o, erd(a));
    @(posedge clk_i);
  endtask : rd
  task automatic ev(input int n, input int exp);
    int base;
    base = n_start;
    repeat (2 * n) begin
      sync_pin_i <= ~sync_pin_i;
      repeat (5) @(posedge clk_i);
    end
    chk(n_start - base, exp);
  endtask : ev
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  // ==========================================================
  // Main sequence: reset values, sync edges, random traffic
  initial begin
    for (int i = 0; i < 256; i++) mdl[i] = 8'h00;
    mdl[8'h0a] = 8'h40;
    mdl[8'h0c] = 8'hd1;
    mdl[8'h0d] = 8'hd9;
    mdl[8'h10] = 8'h48;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(pll_cfg_o, ecfg());
    chk(sync_cfg_o, escfg());
    for (int i = 0; i < 8; i++) rd(adr[i]);
    wr(8'h10, 8'h08);
    ev(3, 0);
    wr(8'h10, 8'h88);
    ev(3, 3);
    wr(8'h10, 8'h80);
    ev(3, 3);
    repeat (100) begin
      r = $random(seed);
      // New status needs the two sync stages plus the output edge
      if (r[3]) begin
        pll_stat_i <= pscr_pll_stat_t'(r[14:4]);
        repeat (4) @(posedge clk_i);
      end
      // Sample clock is taken as slow enough that every divider code,
      // divide by two too, keeps the controller clock under 80 MHz
      wr(adr[r[2:0]], r[23:16]);
      rd(adr[r[26:24]]);
      chk(pll_cfg_o, ecfg());
      chk(sync_cfg_o, escfg());
    end
    summarize();
  end
  // Hang guard, far beyond the thousand or fewer cycles needed
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    summarize();
  end
endmodule : pscr_top_tb
`default_nettype wire
